// ===== rtl/dli_regs.vh
// Constants of the die-link initiator: register offsets, fields, resets.
// Included by the initiator top and its checker; nothing else defines these names.
`ifndef DLI_REGS_VH
`define DLI_REGS_VH

// APB address layout, byte addresses, 12 address bits
`define DLI_ADDR_W 12
`define DLI_WIN_CTRL 2'h0
`define DLI_WIN_BLK 2'h1
`define DLI_WIN_NBLK 2'h2

// Control set: eight word registers, word index within the set
`define DLI_IDX_CTL0 3'h0
`define DLI_IDX_STAT 3'h1
`define DLI_IDX_IST 3'h2
`define DLI_IDX_IMSK 3'h3
`define DLI_IDX_RDAT 3'h4

// Control register 0 fields
`define DLI_CTL_EN 0
`define DLI_CTL_W8 1
`define DLI_CTL_HALT 2
`define DLI_CTL_RST 3'h0

// Status register fields
`define DLI_ST_BUSY 0
`define DLI_ST_LOCK 1
`define DLI_ST_TIRQ 2

// Interrupt status and mask fields
`define DLI_IRQ_TGT 0
`define DLI_IRQ_DONE 1
`define DLI_IRQ_ERR 2
`define DLI_IRQ_RST 3'h0

// Half period of the link clock in bus clock cycles
`define DLI_LINK_HALF 4

`endif

// ===== rtl/dli_sync.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/100ps

module dli_sync #(
   parameter W = 1
) (
   input wire clk_i,
   input wire rst_i,
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);

reg [W-1:0] meta_ff;
reg [W-1:0] sync_ff;

always @(posedge clk_i)
begin
   if (rst_i)
   begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
   end
   else
   begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
   end
end

assign q_o = sync_ff;

endmodule // dli_sync

// ===== rtl/dli_top.v
// Die-link initiator: APB register slave, link clock, data and irq pins.
// Assumes APB master on clk_i; stop and special mode come from clk_i logic.
//
// Contract
// - six or ten pins used, only when enabled
// - enabled interface drives link clock output
// - clock low if disabled or halted stop
// - eight-bit width: upper pins carry bits 7:4
// - four-bit or disabled releases upper pins
// - enabled: lower pins carry bits 3:0
// - enabled input data pins get pull-downs
// - target irq pin is active-high input
// - irq pin pull-down only while enabled
// - stop mode drives the used data pins low
// - disabled: clock and irq pins to GPIO
// - special mode lifts write-once locking
// - eight control registers in address space
// - blocking window stalls until link completes
// - non-blocking window releases requester early
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "dli_regs.vh"

module dli_top #(
   parameter HALF = `DLI_LINK_HALF
) (
   input wire clk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [`DLI_ADDR_W-1:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   input wire stop_mode_i,
   input wire special_mode_i,
   output wire link_clock_pin_o,
   output wire link_clock_pin_oe_o,
   input wire [7:0] link_data_pins_i,
   output wire [7:0] link_data_pins_o,
   output wire [7:0] link_data_pins_oe_o,
   output wire [7:0] link_data_pd_o,
   input wire target_irq_pin_i,
   output wire target_irq_pd_o,
   output wire own_clock_pin_o,
   output wire own_data_lo_o,
   output wire own_data_hi_o,
   output wire own_irq_pin_o,
   output wire irq_o
);

localparam S_IDLE = 4'b0001;
localparam S_XMIT = 4'b0010;
localparam S_TURN = 4'b0100;
localparam S_RECV = 4'b1000;
localparam [31:0] PH_LAST_W = HALF - 1;
localparam [7:0] PH_LAST = PH_LAST_W[7:0];

// Configuration and software-visible state
reg [2:0] ctl_ff;
reg lock_ff;
reg [2:0] ist_ff;
reg [2:0] imsk_ff;
reg [7:0] rdat_ff;

// APB answer
reg pready_ff;
reg pslverr_ff;
reg [31:0] prdata_ff;
reg wait_ff;

// Link engine
reg [3:0] state_ff;
reg [23:0] sr_ff;
reg [2:0] cnt_ff;
reg [7:0] rx_ff;
reg [7:0] drv_ff;
reg drv_oe_ff;
reg tx_wr_ff;
reg tx_nb_ff;
reg done_ff;
reg derr_ff;
reg req_ff;
reg req_wr_ff;
reg req_nb_ff;
reg [7:0] req_addr_ff;
reg [7:0] req_data_ff;
reg [7:0] ph_ff;
reg lclk_ff;

// Pin drivers
reg clk_pin_ff;
reg clk_oe_ff;
reg [7:0] dat_o_ff;
reg [7:0] dat_oe_ff;
reg [7:0] dat_pd_ff;
reg irq_pd_ff;
reg own_clk_ff;
reg own_lo_ff;
reg own_hi_ff;
reg own_irq_ff;
reg irq_ff;

wire [8:0] pins_sync;
wire [7:0] rxs;
wire tirq_s;

dli_sync #(
   .W(9)
) u_sync (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .d_i({target_irq_pin_i, link_data_pins_i}),
   .q_o(pins_sync)
);

assign rxs = pins_sync[7:0];
assign tirq_s = pins_sync[8];

wire en = ctl_ff[`DLI_CTL_EN];
wire w8 = ctl_ff[`DLI_CTL_W8];
wire gated = ~en | (stop_mode_i & ctl_ff[`DLI_CTL_HALT]);
wire fall_tick = ~gated & lclk_ff & (ph_ff == PH_LAST);
wire link_idle = state_ff[0];

// APB decode
wire [1:0] win = paddr_i[11:10];
wire [2:0] word = paddr_i[4:2];
wire ctl_hit = (win == `DLI_WIN_CTRL) & (paddr_i[9:5] == 5'h00);
wire acc = psel_i & penable_i & ~pready_ff;
wire fin = psel_i & penable_i & pready_ff & ~pslverr_ff;
wire win_ok = en & ((win == `DLI_WIN_BLK) | (win == `DLI_WIN_NBLK));
wire launch_blk = acc & win_ok & (win == `DLI_WIN_BLK) & ~wait_ff &
   ~req_ff & link_idle;
wire launch_nb = acc & win_ok & (win == `DLI_WIN_NBLK) & ~req_ff;
wire launch = launch_blk | launch_nb;
wire wr_fin = fin & pwrite_i & ctl_hit;
wire rd_fin = fin & ~pwrite_i & ctl_hit;

reg [31:0] ctl_rd;

always @*
begin
   ctl_rd = 32'h0000_0000;
   case (word)
      `DLI_IDX_CTL0: ctl_rd = {29'h0, ctl_ff};
      `DLI_IDX_STAT: ctl_rd = {29'h0, tirq_s, lock_ff, ~link_idle};
      `DLI_IDX_IST: ctl_rd = {29'h0, ist_ff};
      `DLI_IDX_IMSK: ctl_rd = {29'h0, imsk_ff};
      `DLI_IDX_RDAT: ctl_rd = {24'h0, rdat_ff};
      default: ctl_rd = 32'h0000_0000;
   endcase
end

// APB answer: one wait state for control, link-paced for blocking window
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      wait_ff <= 1'b0;
   end
   else
   begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      if (acc)
      begin
         if (win == `DLI_WIN_CTRL)
         begin
            pready_ff <= 1'b1;
            pslverr_ff <= ~ctl_hit;
            prdata_ff <= ctl_hit ? ctl_rd : 32'h0000_0000;
         end
         else if (~win_ok)
         begin
            pready_ff <= 1'b1;
            pslverr_ff <= 1'b1;
            prdata_ff <= 32'h0000_0000;
         end
         else if (win == `DLI_WIN_BLK)
         begin
            if (launch_blk)
               wait_ff <= 1'b1;
            else if (wait_ff & done_ff)
            begin
               pready_ff <= 1'b1;
               pslverr_ff <= derr_ff;
               prdata_ff <= {24'h0, tx_wr_ff ? 8'h00 : rx_ff};
               wait_ff <= 1'b0;
            end
         end
         else if (launch_nb)
         begin
            pready_ff <= 1'b1;
            prdata_ff <= 32'h0000_0000;
         end
      end
      else if (~psel_i)
         wait_ff <= 1'b0;
   end
end

// Control register 0 write-once outside special mode, mask always writable
always @(posedge clk_i)
begin
   if (rst_i)
   begin
      ctl_ff <= `DLI_CTL_RST;
      lock_ff <= 1'b0;
      imsk_ff <= `DLI_IRQ_RST;
   end
   else if (wr_fin)
   begin
      if (word == `DLI_IDX_CTL0 & (~lock_ff | special_mode_i))
      begin
         ctl_ff <= pwdata_i[2:0];
         lock_ff <= ~special_mode_i;
      end
      if (word == `DLI_IDX_IMSK)
         imsk_ff <= pwdata_i[2:0];
   end
end

// Sticky events; only bits seen by the read are cleared, set wins
wire [2:0] ist_set = {done_ff & derr_ff, done_ff & tx_nb_ff & ~derr_ff,
   en & tirq_s};
wire [2:0] ist_clr = (rd_fin & word == `DLI_IDX_IST) ?
   prdata_ff[2:0] : 3'h0;

always @(posedge clk_i)
begin
   if (rst_i)
   begin
      ist_ff <= `DLI_IRQ_RST;
      irq_ff <= 1'b0;
   end
   else
   begin
      ist_ff <= (ist_ff & ~ist_clr) | ist_set;
      irq_ff <= |(ist_ff & imsk_ff);
   end
end

// Link clock divider, held low when gated
always @(posedge clk_i)
begin
   if (rst_i | gated)
   begin
      ph_ff <= 8'h00;
      lclk_ff <= 1'b0;
   end
   else if (ph_ff == PH_LAST)
   begin
      ph_ff <= 8'h00;
      lclk_ff <= ~lclk_ff;
   end
   else
      ph_ff <= ph_ff + 8'h01;
end

// Link frame: command, address, then write data or turnaround and read
wire [23:0] ld = {req_wr_ff, 7'h00, req_addr_ff, req_data_ff};
wire [7:0] rx_nxt = w8 ? rxs : {rx_ff[3:0], rxs[3:0]};

always @(posedge clk_i)
begin
   if (rst_i)
   begin
      state_ff <= S_IDLE;
      sr_ff <= 24'h00_0000;
      cnt_ff <= 3'h0;
      rx_ff <= 8'h00;
      rdat_ff <= 8'h00;
      drv_ff <= 8'h00;
      drv_oe_ff <= 1'b0;
      tx_wr_ff <= 1'b0;
      tx_nb_ff <= 1'b0;
      done_ff <= 1'b0;
      derr_ff <= 1'b0;
      req_ff <= 1'b0;
      req_wr_ff <= 1'b0;
      req_nb_ff <= 1'b0;
      req_addr_ff <= 8'h00;
      req_data_ff <= 8'h00;
   end
   else
   begin
      done_ff <= 1'b0;
      if (launch)
      begin
         req_ff <= 1'b1;
         req_wr_ff <= pwrite_i;
         req_nb_ff <= launch_nb;
         req_addr_ff <= paddr_i[9:2];
         req_data_ff <= pwdata_i[7:0];
      end
      if (~en)
      begin
         req_ff <= 1'b0;
         drv_oe_ff <= 1'b0;
         state_ff <= S_IDLE;
         if (~link_idle)
         begin
            done_ff <= 1'b1;
            derr_ff <= 1'b1;
         end
      end
      else if (fall_tick)
      begin
         case (state_ff)
            S_IDLE:
            begin
               if (req_ff)
               begin
                  req_ff <= 1'b0;
                  tx_wr_ff <= req_wr_ff;
                  tx_nb_ff <= req_nb_ff;
                  derr_ff <= 1'b0;
                  drv_oe_ff <= 1'b1;
                  drv_ff <= w8 ? ld[23:16] : {4'h0, ld[23:20]};
                  sr_ff <= w8 ? {ld[15:0], 8'h00} : {ld[19:0], 4'h0};
                  if (req_wr_ff)
                     cnt_ff <= w8 ? 3'h2 : 3'h5;
                  else
                     cnt_ff <= w8 ? 3'h1 : 3'h3;
                  state_ff <= S_XMIT;
               end
            end
            S_XMIT:
            begin
               if (cnt_ff == 3'h0)
               begin
                  drv_oe_ff <= 1'b0;
                  if (tx_wr_ff)
                  begin
                     done_ff <= 1'b1;
                     state_ff <= S_IDLE;
                  end
                  else
                     state_ff <= S_TURN;
               end
               else
               begin
                  drv_ff <= w8 ? sr_ff[23:16] : {4'h0, sr_ff[23:20]};
                  sr_ff <= w8 ? {sr_ff[15:0], 8'h00} :
                     {sr_ff[19:0], 4'h0};
                  cnt_ff <= cnt_ff - 3'h1;
               end
            end
            S_TURN:
            begin
               cnt_ff <= w8 ? 3'h0 : 3'h1;
               state_ff <= S_RECV;
            end
            S_RECV:
            begin
               rx_ff <= rx_nxt;
               if (cnt_ff == 3'h0)
               begin
                  rdat_ff <= rx_nxt;
                  done_ff <= 1'b1;
                  state_ff <= S_IDLE;
               end
               else
                  cnt_ff <= cnt_ff - 3'h1;
            end
            default:
               state_ff <= S_IDLE;
         endcase
      end
   end
end

// Pin ownership, direction, pull-downs
wire [7:0] lanes = en ? (w8 ? 8'hFF : 8'h0F) : 8'h00;
wire halt_dat = en & stop_mode_i;
wire [7:0] oe_nxt = halt_dat ? lanes : ({8{drv_oe_ff}} & lanes);

always @(posedge clk_i)
begin
   if (rst_i)
   begin
      clk_pin_ff <= 1'b0;
      clk_oe_ff <= 1'b0;
      dat_o_ff <= 8'h00;
      dat_oe_ff <= 8'h00;
      dat_pd_ff <= 8'h00;
      irq_pd_ff <= 1'b0;
      own_clk_ff <= 1'b0;
      own_lo_ff <= 1'b0;
      own_hi_ff <= 1'b0;
      own_irq_ff <= 1'b0;
   end
   else
   begin
      clk_pin_ff <= lclk_ff;
      clk_oe_ff <= en;
      dat_o_ff <= halt_dat ? 8'h00 : (drv_ff & lanes);
      dat_oe_ff <= oe_nxt;
      dat_pd_ff <= lanes & ~oe_nxt;
      irq_pd_ff <= en;
      own_clk_ff <= en;
      own_irq_ff <= en;
      own_lo_ff <= en;
      own_hi_ff <= en & w8;
   end
end

assign prdata_o = prdata_ff;
assign pready_o = pready_ff;
assign pslverr_o = pslverr_ff;
assign link_clock_pin_o = clk_pin_ff;
assign link_clock_pin_oe_o = clk_oe_ff;
assign link_data_pins_o = dat_o_ff;
assign link_data_pins_oe_o = dat_oe_ff;
assign link_data_pd_o = dat_pd_ff;
assign target_irq_pd_o = irq_pd_ff;
assign own_clock_pin_o = own_clk_ff;
assign own_data_lo_o = own_lo_ff;
assign own_data_hi_o = own_hi_ff;
assign own_irq_pin_o = own_irq_ff;
assign irq_o = irq_ff;

endmodule // dli_top

// ===== tb/dli_top_props.sv
// Checker for the die-link initiator pins and APB answer.
// Assumes binding to dli_top; sees its ports only.
`timescale 1ns/100ps
`include "dli_regs.vh"
module dli_top_props #(
   parameter HALF = 4
) (
   input wire clk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire [`DLI_ADDR_W-1:0] paddr_i,
   input wire pready_o,
   input wire pslverr_o,
   input wire stop_mode_i,
   input wire link_clock_pin_o,
   input wire link_clock_pin_oe_o,
   input wire [7:0] link_data_pins_o,
   input wire [7:0] link_data_pins_oe_o,
   input wire [7:0] link_data_pd_o,
   input wire target_irq_pd_o,
   input wire own_clock_pin_o,
   input wire own_data_lo_o,
   input wire own_data_hi_o,
   input wire own_irq_pin_o
);
   localparam int TGL = HALF + 1;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_go;
      (own_clock_pin_o && !stop_mode_i)[*8];
   endsequence
   sequence s_stop;
      (stop_mode_i && own_data_lo_o)[*3];
   endsequence
   sequence s_ctl;
      $rose(psel_i && penable_i) && paddr_i[11:5] == 7'h00;
   endsequence
   chk_clk_owner: assert property (
      link_clock_pin_oe_o == own_clock_pin_o)
      else $error("clock drive differs from pin ownership");
   chk_clk_off: assert property (
      !own_clock_pin_o && $past(!own_clock_pin_o) |-> !link_clock_pin_o)
      else $error("link clock high while disabled");
   // Disable or stop may legally halt the clock inside the window
   chk_clk_runs: assert property (
      s_go |-> ##[0:TGL] ($changed(link_clock_pin_o) || !own_clock_pin_o
      || stop_mode_i))
      else $error("link clock stuck while running");
   chk_irq_pd: assert property (target_irq_pd_o == own_irq_pin_o)
      else $error("irq pull-down not tied to enable");
   chk_hi_free: assert property (
      !own_data_hi_o && $past(!own_data_hi_o)
      |-> (link_data_pins_oe_o[7:4] | link_data_pd_o[7:4]) == 4'h0)
      else $error("upper lanes used while released");
   chk_pd_input: assert property (
      (link_data_pd_o & link_data_pins_oe_o) == 8'h00)
      else $error("pull-down on a driven lane");
   chk_pd_lanes: assert property (
      own_data_lo_o && $past(own_data_lo_o)
      && link_data_pins_oe_o[3:0] == 4'h0 |-> link_data_pd_o[3:0] == 4'hF)
      else $error("input lane without pull-down");
   chk_stop_low: assert property (s_stop |-> link_data_pins_o == 8'h00)
      else $error("data lane high in stop");
   chk_ctl_answer: assert property (s_ctl |-> ##1 (pready_o && !pslverr_o))
      else $error("control access not answered");
endmodule // dli_top_props
bind dli_top dli_top_props #(.HALF(HALF)) dli_top_props_inst (
   .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .stop_mode_i(stop_mode_i), .link_clock_pin_o(link_clock_pin_o),
   .link_clock_pin_oe_o(link_clock_pin_oe_o),
   .link_data_pins_o(link_data_pins_o),
   .link_data_pins_oe_o(link_data_pins_oe_o),
   .link_data_pd_o(link_data_pd_o), .target_irq_pd_o(target_irq_pd_o),
   .own_clock_pin_o(own_clock_pin_o), .own_data_lo_o(own_data_lo_o),
   .own_data_hi_o(own_data_hi_o), .own_irq_pin_o(own_irq_pin_o)
);

// ===== tb/dli_target_model.sv
// Target die model: answers read frames, drives the irq pin.
// Assumes the bench arms it around each blocking read.
`timescale 1ns/100ps
module dli_target_model (
   input wire rst_i,
   input wire lclk_i,
   input wire wide_i,
   input wire [7:0] oe_i,
   input wire arm_i,
   input wire [7:0] reply_i,
   input wire irq_req_i,
   output logic drv_o,
   output logic [7:0] dat_o,
   output wire irq_o
);
   logic [1:0] hist;
   logic step;
   assign irq_o = irq_req_i;
   // Lane 0 direction, taken mid-period where it is stable
   always @(posedge lclk_i or posedge rst_i)
   begin
      if (rst_i)
         hist <= 2'b00;
      else
         hist <= {hist[0], oe_i[0]};
   end
   // After one full turn period: one byte, or high then low nibble
   always @(negedge lclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         step <= 1'b0;
         drv_o <= 1'b0;
         dat_o <= 8'h00;
      end
      else
      begin
         drv_o <= 1'b0;
         step <= 1'b0;
         if (arm_i && hist == 2'b10)
         begin
            drv_o <= 1'b1;
            dat_o <= wide_i ? reply_i : {4'h0, reply_i[7:4]};
            step <= !wide_i;
         end
         else if (step)
         begin
            drv_o <= 1'b1;
            dat_o <= {4'h0, reply_i[3:0]};
         end
      end
   end
endmodule // dli_target_model

// ===== tb/dli_top_tb.sv
// Bench for the die-link initiator: APB tasks and pin checks.
// Assumes the checker binds itself; target model on the link.
`timescale 1ns/100ps
module dli_top_tb;
   logic clk_i, rst_i, psel_i, penable_i, pwrite_i, err, seen;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic pready_o, pslverr_o, stop_mode_i, special_mode_i, irq_o;
   logic link_clock_pin_o, link_clock_pin_oe_o, target_irq_pd_o;
   logic [7:0] link_data_pins_i, link_data_pins_o, link_data_pins_oe_o;
   logic [7:0] link_data_pd_o, mdat, reply;
   logic own_clock_pin_o, own_data_lo_o, own_data_hi_o, own_irq_pin_o;
   logic target_irq_pin_i, irq_req, drv, arm;
   int n_mismatch, n_checks, waits, tgl;
   // Released lanes fall to the pull-down, else float high
   assign link_data_pins_i = (link_data_pins_oe_o & link_data_pins_o)
      | (~link_data_pins_oe_o & (drv ? mdat : ~link_data_pd_o));
   dli_top #(.HALF(10)) dli_top_inst (
      .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .stop_mode_i(stop_mode_i), .special_mode_i(special_mode_i),
      .link_clock_pin_o(link_clock_pin_o),
      .link_clock_pin_oe_o(link_clock_pin_oe_o),
      .link_data_pins_i(link_data_pins_i),
      .link_data_pins_o(link_data_pins_o),
      .link_data_pins_oe_o(link_data_pins_oe_o),
      .link_data_pd_o(link_data_pd_o), .target_irq_pin_i(target_irq_pin_i),
      .target_irq_pd_o(target_irq_pd_o), .own_clock_pin_o(own_clock_pin_o),
      .own_data_lo_o(own_data_lo_o), .own_data_hi_o(own_data_hi_o),
      .own_irq_pin_o(own_irq_pin_o), .irq_o(irq_o));
   dli_target_model dli_target_model_inst (
      .rst_i(rst_i), .lclk_i(link_clock_pin_o), .wide_i(own_data_hi_o),
      .oe_i(link_data_pins_oe_o), .arm_i(arm), .reply_i(reply),
      .irq_req_i(irq_req), .drv_o(drv), .dat_o(mdat),
      .irq_o(target_irq_pin_i));
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
      if (link_data_pins_oe_o[0] && link_data_pins_o == 8'h5A) seen <= 1'b1;
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      waits = 0;
      // Answer looked at mid-cycle; release on the edge it is taken
      do
      begin
         @(negedge clk_i);
         waits++;
      end while (pready_o !== 1'b1 && waits < 4000);
      if (pready_o !== 1'b1) n_mismatch++;
      rd = prdata_o;
      err = pslverr_o;
      @(posedge clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic count_tgl(input int n);
      logic last;
      tgl = 0;
      @(negedge clk_i);
      last = link_clock_pin_o;
      repeat (n)
      begin
         @(negedge clk_i);
         if (link_clock_pin_o !== last) tgl++;
         last = link_clock_pin_o;
      end
      @(posedge clk_i);
   endtask
   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_mismatch++;
      wrap_up;
   end
   initial
   begin
      {n_mismatch, n_checks, psel_i, penable_i, pwrite_i} = 0;
      {paddr_i, pwdata_i, stop_mode_i, special_mode_i} = 0;
      {irq_req, arm, reply, seen} = 0;
      rst_i = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      // Disabled: pins released, windows and holes refused
      count_tgl(16);
      chk(tgl, 0);
      chk({own_clock_pin_o, own_data_lo_o, target_irq_pd_o, link_data_pd_o}, 0);
      apb(1'b1, 12'h404, 32'h5A);
      chk(err, 1);
      apb(1'b0, 12'hC00, 0);
      chk(err, 1);
      apb(1'b0, 12'h020, 0);
      chk(err, 1);
      apb(1'b0, 12'h014, 0);
      chk({err, rd}, 0);
      apb(1'b0, 12'h000, 0);
      chk({err, rd}, 0);
      // Enable at eight bits; second write locked out
      apb(1'b1, 12'h000, 32'h3);
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b0, 12'h000, 0);
      chk(rd, 3);
      count_tgl(80);
      chk(tgl, 8);
      chk({own_data_hi_o, own_irq_pin_o, target_irq_pd_o, link_data_pd_o}, 11'h7FF);
      apb(1'b1, 12'h404, 32'h5A);
      chk({err, seen, waits > 16}, 3'h3);
      reply <= 8'hC3;
      arm <= 1'b1;
      apb(1'b0, 12'h408, 0);
      chk({err, rd[7:0]}, 9'h0C3);
      arm <= 1'b0;
      apb(1'b1, 12'h804, 32'hA5);
      chk({err, waits}, 2);
      repeat (120) @(posedge clk_i);
      apb(1'b0, 12'h008, 0);
      chk(rd[2:0], 3'h2);
      // Special mode: four-bit width, nibble read
      special_mode_i <= 1'b1;
      apb(1'b1, 12'h000, 32'h1);
      repeat (3) @(posedge clk_i);
      chk({own_data_hi_o, link_data_pd_o}, 9'h00F);
      reply <= 8'h96;
      arm <= 1'b1;
      apb(1'b0, 12'h40C, 0);
      chk({err, rd[7:0]}, 9'h096);
      arm <= 1'b0;
      // Stop: lanes low, clock halts only with the halt bit
      apb(1'b1, 12'h000, 32'h3);
      stop_mode_i <= 1'b1;
      count_tgl(80);
      chk({tgl, link_data_pins_o}, {32'd8, 8'h00});
      apb(1'b1, 12'h000, 32'h7);
      repeat (3) @(posedge clk_i);
      count_tgl(32);
      chk({tgl, link_clock_pin_o}, 0);
      stop_mode_i <= 1'b0;
      // Target irq through status and mask
      apb(1'b1, 12'h00C, 32'h1);
      irq_req <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk(irq_o, 1);
      irq_req <= 1'b0;
      repeat (8) @(posedge clk_i);
      apb(1'b0, 12'h008, 0);
      chk(rd[0], 1);
      repeat (4) @(posedge clk_i);
      chk(irq_o, 0);
      apb(1'b1, 12'h00C, 0);
      irq_req <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk(irq_o, 0);
      irq_req <= 1'b0;
      apb(1'b1, 12'h000, 0);
      repeat (3) @(posedge clk_i);
      chk({own_clock_pin_o, own_irq_pin_o, target_irq_pd_o, link_data_pd_o}, 0);
      wrap_up;
   end
endmodule // dli_top_tb
